// *** flash_self_prog_pkg.sv ***
// Constants for the flash self-programming sequencer
package flash_self_prog_pkg;
   localparam int CLK_MHZ = 100;
   // Flash operation time window in microseconds
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int PROG_CYCLES_MIN = PROG_MIN_US * CLK_MHZ;
   localparam int PROG_CYCLES_MAX = PROG_MAX_US * CLK_MHZ;
   // Store must follow control write within this many cycles
   localparam logic [2:0] CMD_WINDOW = 3'h4;
   // Register offsets on the plain register port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_PTR_LO = 4'h1;
   localparam logic [3:0] OFS_PTR_HI = 4'h2;
   localparam logic [3:0] OFS_DATA_LO = 4'h3;
   localparam logic [3:0] OFS_DATA_HI = 4'h4;
   localparam logic [3:0] OFS_STORE = 4'h5;
   localparam logic [3:0] OFS_LOCK = 4'h6;
   localparam logic [3:0] OFS_LOAD_RD = 4'h7;
   // Control register fields
   localparam int BIT_ENABLE = 0;
   localparam int BIT_ERASE = 1;
   localparam int BIT_WRITE = 2;
   localparam int BIT_LOCK = 3;
   localparam int BIT_REENABLE = 4;
   localparam int BIT_BUSY = 6;
   localparam int BIT_IRQ_EN = 7;
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCKSET = 5'h09;
   localparam logic [4:0] CMD_REEN = 5'h11;
   // Page geometry: 64 words a page, 512 pages
   localparam int WORD_BITS = 6;
   localparam int PAGE_WORDS = 64;
   localparam logic [15:0] APP_RESET_VEC = 16'h0000;
   localparam logic [5:0] LOCK_RESET = 6'h3f;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} prog_state_t;
endpackage : flash_self_prog_pkg

// *** flash_self_program_ctrl.sv ***
// Self-programming sequencer for on-chip program flash
// Behaviour
// [RULE1] Reset vector is 0x0000 if boot fuse is one, boot start if zero.
// [RULE2] Target address is captured at start; later pointer writes do not matter.
// [RULE3] Lock-bit setting ignores the pointer entirely.
// [RULE4] Program-memory reads are byte wide; pointer bit 0 picks low or high byte.
// [RULE5] Control X0000011 then store within four cycles erases page; data ignored.
// [RULE6] Work on the rww section keeps fetch running; other section halts the core.
// [RULE7] Control 00000001 then store loads data word at the pointer word position.
// [RULE8] Page buffer clears after page write, re-enable write, and system reset.
// [RULE9] Software loads each buffer word at most once between clears.
// [RULE10] An EEPROM write during buffer loading discards the whole buffer.
// [RULE11] Control X0000101 then store writes page; other pointer bits must be zero.
// [RULE12] Software gives the same page to erase and the later write.
// [RULE13] With interrupt enabled, interrupt is high while the enable bit is clear.
// [RULE14] Erase or write blocks rww reads and holds the busy flag.
// [RULE15] Busy flag stays set after completion until re-enable is written.
// [RULE16] Control X0001001 then store sets lock bits from data low byte.
// [RULE17] Zero in data bits 5..0 programs that lock bit; one leaves it.
// [RULE18] Software should use pointer 0x0001 and data bits 7:6 set for locks.
// [RULE19] Lock programming never blocks reads or halts the core.
// [RULE20] While EEPROM write is active, commands and lock reads are refused.
// [RULE21] Software should check EEPROM write flag before writing control.
// [RULE22] Loads accepted in any order, before or after erase.
// [RULE23] Command and enable clear if no store follows within four cycles.
// [RULE24] Erase, write and lock take 3.7 ms to 4.5 ms.
// [RULE25] Enable bit stays set during an operation and clears when it ends.
`timescale 1ns/1ps
module flash_self_program_ctrl
   import flash_self_prog_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
   input wire logic core_clk, // System clock
   input wire logic sys_rst, // Asynchronous reset, active high
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic boot_reset_fuse, // Boot reset fuse, 0 programmed
   input wire logic [15:0] boot_start_addr, // Boot loader start word address
   input wire logic [15:0] rww_limit, // First word address of no-rww section
   input wire logic eeprom_write_active, // EEPROM write in progress
   output logic [15:0] reset_vector, // Selected reset vector
   output logic cpu_halt, // Halts the core during no-rww work
   output logic rww_read_block, // Reads of rww section blocked
   output logic prog_irq, // Completion interrupt level
   output logic flash_erase_req, // Erase pulse to flash array
   output logic flash_write_req, // Page write pulse to flash array
   output logic [15:0] flash_page_addr, // Latched page address (word)
   output logic [5:0] lock_bits // Current lock bits, 0 programmed
);

   logic [1:0] fuse_sync;
   logic [1:0] ee_sync;
   logic ee_active;
   prog_state_t state;
   logic [4:0] cmd;
   logic irq_en;
   logic busy_flag;
   logic [2:0] window_cnt;
   logic [31:0] op_cnt;
   logic [4:0] op_cmd;
   logic op_no_read_while_write_section;
   logic [15:0] pointer;
   logic [15:0] data_word;
   logic [15:0] page_buf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] buf_valid;
   logic loading;
   logic store_hit;
   logic ctrl_hit;
   logic op_done;
   logic [7:0] ctrl_value;

   function automatic logic is_reg(input logic [3:0] addr, input logic [3:0] ofs);
      is_reg = (addr == ofs);
   endfunction : is_reg

   // Fuse and EEPROM status come from other logic domains
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fuse_sync <= 2'h3;
         ee_sync <= 2'h0;
      end else begin
         fuse_sync <= {fuse_sync[0], boot_reset_fuse};
         ee_sync <= {ee_sync[0], eeprom_write_active};
      end
   end
   assign ee_active = ee_sync[1];

   // Fuse choice taken after release; async reset loads the application vector
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_vector <= APP_RESET_VEC;
      end else begin
         reset_vector <= fuse_sync[1] ? APP_RESET_VEC : boot_start_addr; // see [RULE1]
      end
   end

   assign ctrl_hit = reg_wr && is_reg(reg_addr, OFS_CTRL) && !ee_active; // see [RULE20]
   assign store_hit = reg_wr && is_reg(reg_addr, OFS_STORE) && state == ST_ARMED;
   assign op_done = state == ST_BUSY && op_cnt == PROG_CYCLES - 1; // see [RULE24]

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pointer <= 16'h0000;
         data_word <= 16'h0000;
      end else if (reg_wr) begin
         if (is_reg(reg_addr, OFS_PTR_LO)) begin
            pointer[7:0] <= reg_wdata;
         end
         if (is_reg(reg_addr, OFS_PTR_HI)) begin
            pointer[15:8] <= reg_wdata;
         end
         if (is_reg(reg_addr, OFS_DATA_LO)) begin
            data_word[7:0] <= reg_wdata;
         end
         if (is_reg(reg_addr, OFS_DATA_HI)) begin
            data_word[15:8] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_en <= 1'b0;
      end else if (reg_wr && is_reg(reg_addr, OFS_CTRL)) begin
         irq_en <= reg_wdata[BIT_IRQ_EN];
      end
   end

   // Command sequencer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         cmd <= 5'h00;
         window_cnt <= 3'h0;
         op_cnt <= 32'h0;
         op_cmd <= 5'h00;
         op_no_read_while_write_section <= 1'b0;
         flash_page_addr <= 16'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (ctrl_hit && reg_wdata[BIT_ENABLE]) begin
                  cmd <= reg_wdata[4:0];
                  window_cnt <= 3'h0;
                  state <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (store_hit && !ee_active) begin // see [RULE20]
                  if (cmd == CMD_ERASE || cmd == CMD_WRITE) begin
                     // Pointer is a byte address; the latched page is a word address
                     flash_page_addr <= {1'b0, pointer[15:WORD_BITS+1], {WORD_BITS{1'b0}}}; // see [RULE2] [RULE5]
                     op_no_read_while_write_section <= pointer[15:1] >= rww_limit[14:0]; // see [RULE6]
                     op_cmd <= cmd;
                     op_cnt <= 32'h0;
                     state <= ST_BUSY;
                  end else if (cmd == CMD_LOCKSET) begin
                     op_no_read_while_write_section <= 1'b0; // see [RULE3] [RULE19]
                     op_cmd <= cmd;
                     op_cnt <= 32'h0;
                     state <= ST_BUSY;
                  end else begin
                     cmd <= 5'h00;
                     state <= ST_IDLE;
                  end
               end else if (window_cnt == CMD_WINDOW - 3'h1 || ee_active) begin
                  cmd <= 5'h00; // see [RULE23]
                  state <= ST_IDLE;
               end else begin
                  window_cnt <= window_cnt + 3'h1;
               end
            end
            ST_BUSY: begin
               op_cnt <= op_cnt + 32'h1;
               if (op_done) begin
                  cmd <= 5'h00; // see [RULE25]
                  op_no_read_while_write_section <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   assign flash_erase_req = store_hit && !ee_active && cmd == CMD_ERASE;
   assign flash_write_req = store_hit && !ee_active && cmd == CMD_WRITE; // see [RULE11]

   // Busy set on start, held until re-enable store; set beats clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_flag <= 1'b0;
      end else if (flash_erase_req || flash_write_req) begin
         busy_flag <= 1'b1; // see [RULE14]
      end else if (store_hit && !ee_active && cmd == CMD_REEN && state != ST_BUSY) begin
         busy_flag <= 1'b0; // see [RULE15]
      end
   end

   assign rww_read_block = busy_flag; // see [RULE14]
   assign cpu_halt = state == ST_BUSY && op_no_read_while_write_section; // see [RULE6]
   assign prog_irq = irq_en && state != ST_BUSY && state != ST_ARMED; // see [RULE13]

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_bits <= LOCK_RESET;
      end else if (store_hit && !ee_active && cmd == CMD_LOCKSET) begin
         lock_bits <= lock_bits & data_word[5:0]; // see [RULE16] [RULE17]
      end
   end

   // Loading window marks buffer activity for the EEPROM interlock
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         loading <= 1'b0;
      end else if (flash_write_req) begin
         loading <= 1'b0;
      end else if (store_hit && cmd == CMD_LOAD && !ee_active) begin
         loading <= 1'b1;
      end else if (ee_active) begin
         loading <= 1'b0;
      end
   end

   // Valid map makes clearing a single-cycle act instead of a sweep
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_valid <= '0; // see [RULE8]
      end else if (flash_write_req || (store_hit && cmd == CMD_REEN && !ee_active)) begin
         buf_valid <= '0; // see [RULE8]
      end else if (ee_active && loading) begin
         buf_valid <= '0; // see [RULE10]
      end else if (store_hit && cmd == CMD_LOAD && !ee_active) begin
         buf_valid[pointer[WORD_BITS:1]] <= 1'b1; // see [RULE7] [RULE22]
      end
   end

   always_ff @(posedge core_clk) begin
      if (store_hit && cmd == CMD_LOAD && !ee_active) begin
         page_buf[pointer[WORD_BITS:1]] <= data_word; // see [RULE7]
      end
   end

   always_comb begin
      ctrl_value = 8'h00;
      ctrl_value[BIT_IRQ_EN] = irq_en;
      ctrl_value[BIT_BUSY] = busy_flag;
      ctrl_value[4:0] = (state == ST_IDLE) ? 5'h00 : (state == ST_BUSY ? op_cmd : cmd);
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: reg_rdata <= ctrl_value;
            OFS_PTR_LO: reg_rdata <= pointer[7:0];
            OFS_PTR_HI: reg_rdata <= pointer[15:8];
            OFS_DATA_LO: reg_rdata <= data_word[7:0];
            OFS_DATA_HI: reg_rdata <= data_word[15:8];
            OFS_LOCK: reg_rdata <= ee_active ? 8'h00 : {2'h3, lock_bits}; // see [RULE20]
            OFS_LOAD_RD: begin
               if (!buf_valid[pointer[WORD_BITS:1]]) begin
                  reg_rdata <= 8'hff;
               end else if (pointer[0]) begin
                  reg_rdata <= page_buf[pointer[WORD_BITS:1]][15:8]; // see [RULE4]
               end else begin
                  reg_rdata <= page_buf[pointer[WORD_BITS:1]][7:0]; // see [RULE4]
               end
            end
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : flash_self_program_ctrl

// *** flash_self_program_ctrl_monitor.sv ***
// Port checker for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_self_program_ctrl_monitor
   import flash_self_prog_pkg::*;
#(
   parameter int PROG_CYCLES = 20
) (
   input wire logic core_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [3:0] reg_addr, // Address
   input wire logic reg_wr, // Write strobe
   input wire logic boot_reset_fuse, // Fuse
   input wire logic [15:0] boot_start_addr, // Boot start
   input wire logic [15:0] rww_limit, // Section split
   input wire logic eeprom_write_active, // EEPROM busy
   input wire logic [15:0] reset_vector, // Vector
   input wire logic cpu_halt, // Halt
   input wire logic rww_read_block, // Busy flag
   input wire logic prog_irq, // Interrupt
   input wire logic flash_erase_req, // Erase pulse
   input wire logic flash_write_req, // Write pulse
   input wire logic [15:0] flash_page_addr, // Page
   input wire logic [5:0] lock_bits // Locks
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   int busy_cnt;
   // Stops one short of the end so the exact finish edge is not judged
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         busy_cnt <= 0;
      else if (flash_erase_req || flash_write_req)
         busy_cnt <= 1;
      else if (busy_cnt != 0 && busy_cnt < PROG_CYCLES - 1)
         busy_cnt <= busy_cnt + 1;
      else
         busy_cnt <= 0;
   end
   a_vec_app: assert property (boot_reset_fuse [*4] |=> reset_vector == 16'h0000)
      else $error("reset vector not application start");
   a_vec_boot: assert property ((!boot_reset_fuse && $stable(boot_start_addr)) [*4]
      |=> reset_vector == $past(boot_start_addr)) else $error("reset vector not boot start");
   a_start_blocks: assert property (flash_erase_req || flash_write_req |=> rww_read_block)
      else $error("busy flag not set by start");
   a_block_holds: assert property (rww_read_block && !(reg_wr && reg_addr == OFS_STORE)
      |=> rww_read_block) else $error("busy flag dropped without store");
   a_busy_quiet: assert property (busy_cnt != 0 |-> !prog_irq && !flash_erase_req && !flash_write_req)
      else $error("activity during busy span");
   a_halt_no_read_while_write_section: assert property (cpu_halt |-> rww_read_block && flash_page_addr >= rww_limit)
      else $error("halt outside no-rww work");
   a_ee_refuse: assert property (eeprom_write_active [*3] |-> !flash_erase_req && !flash_write_req)
      else $error("start while eeprom busy");
   a_page_align: assert property ($rose(rww_read_block) |-> flash_page_addr[5:0] == 6'h00)
      else $error("page address has word bits");
   a_lock_mono: assert property ((lock_bits & ~$past(lock_bits)) == 6'h00)
      else $error("lock bit returned to one");
endmodule : flash_self_program_ctrl_monitor
bind flash_self_program_ctrl flash_self_program_ctrl_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(boot_start_addr), .rww_limit(rww_limit),
   .eeprom_write_active(eeprom_write_active), .reset_vector(reset_vector), .cpu_halt(cpu_halt),
   .rww_read_block(rww_read_block), .prog_irq(prog_irq), .flash_erase_req(flash_erase_req),
   .flash_write_req(flash_write_req), .flash_page_addr(flash_page_addr), .lock_bits(lock_bits));

// *** flash_prog_core_model.sv ***
// Processor core model issuing register cycles and store commands
`timescale 1ns/1ps
module flash_prog_core_model
   import flash_self_prog_pkg::*;
(
   input wire logic core_clk, // Clock
   output logic [3:0] reg_addr, // Address
   output logic [7:0] reg_wdata, // Write data
   output logic reg_wr, // Write strobe
   output logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata // Read data
);
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Data inverted on release so a stale byte is never mistaken for valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask : rd
   // Gap 0 stores two cycles after the control write, gap 2 at the limit
   task automatic store_cmd(input logic [7:0] cmd, input int gap);
      wr(OFS_CTRL, cmd);
      repeat (gap) @(posedge core_clk);
      wr(OFS_STORE, 8'h00);
   endtask : store_cmd
   task automatic setp(input logic [15:0] p);
      wr(OFS_PTR_LO, p[7:0]);
      wr(OFS_PTR_HI, p[15:8]);
   endtask : setp
   task automatic load(input logic [15:0] p, input logic [15:0] w);
      setp(p);
      wr(OFS_DATA_LO, w[7:0]);
      wr(OFS_DATA_HI, w[15:8]);
      store_cmd({3'h0, CMD_LOAD}, 0);
   endtask : load
endmodule : flash_prog_core_model

// *** flash_self_program_ctrl_test.sv ***
// Self-checking testbench for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_self_program_ctrl_test;
   import flash_self_prog_pkg::*;
   localparam int PC = 20;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic boot_reset_fuse = 1'b1;
   logic [15:0] boot_start_addr = 16'h3c00;
   logic [15:0] rww_limit = 16'h3800;
   logic eeprom_write_active = 1'b0;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [15:0] reset_vector;
   logic cpu_halt;
   logic rww_read_block;
   logic prog_irq;
   logic flash_erase_req;
   logic flash_write_req;
   logic [15:0] flash_page_addr;
   logic [5:0] lock_bits;
   logic halt_seen = 1'b0;
   logic block_seen = 1'b0;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_er = 0;
   int n_wr = 0;
   int t0;
   int n0;
   flash_self_program_ctrl #(.PROG_CYCLES(PC)) flash_self_program_ctrl_i (.core_clk(core_clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(boot_start_addr),
      .rww_limit(rww_limit), .eeprom_write_active(eeprom_write_active), .reset_vector(reset_vector),
      .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .prog_irq(prog_irq),
      .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
      .flash_page_addr(flash_page_addr), .lock_bits(lock_bits));
   flash_prog_core_model core_i (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (flash_erase_req === 1'b1) n_er <= n_er + 1;
      if (flash_write_req === 1'b1) n_wr <= n_wr + 1;
      if (cpu_halt === 1'b1) halt_seen <= 1'b1;
      if (rww_read_block === 1'b1) block_seen <= 1'b1;
      if (cyc == 5000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string n);
      logic [7:0] d;
      core_i.rd(a, d);
      chk(n, {8'h00, e}, {8'h00, d});
   endtask : rdc
   task automatic rdbuf(input logic [15:0] p, input logic [7:0] e);
      core_i.setp(p);
      rdc(OFS_LOAD_RD, e, "buffer");
   endtask : rdbuf
   task automatic wait_op;
      int n;
      n = 0;
      while (prog_irq !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk("op_time", 16'h0001, {15'h0, (cyc - t0 >= PC - 2) && (cyc - t0 <= PC + 6)});
   endtask : wait_op
   task automatic t_vector;
      repeat (5) @(posedge core_clk);
      chk("vector", APP_RESET_VEC, reset_vector);
      boot_reset_fuse <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("vector", boot_start_addr, reset_vector);
      boot_reset_fuse <= 1'b1;
      $display("t_vector done");
   endtask : t_vector
   task automatic t_prog;
      core_i.load(16'h018a, 16'h1234);
      core_i.load(16'h0184, 16'habcd);
      rdbuf(16'h018b, 8'h12);
      rdbuf(16'h018a, 8'h34);
      rdbuf(16'h0186, 8'hff);
      n0 = n_er;
      core_i.setp(16'h018e);
      core_i.store_cmd({3'h4, CMD_ERASE}, 0);
      t0 = cyc;
      core_i.setp(16'h0000);
      chk("page", 16'h00c0, flash_page_addr);
      rdc(OFS_CTRL, 8'hc3, "ctrl");
      wait_op();
      chk("erases", n0 + 1, n_er);
      chk("halt", 16'h0, {15'h0, halt_seen});
      chk("busy", 16'h1, {15'h0, rww_read_block});
      rdbuf(16'h0184, 8'hcd);
      rww_limit <= 16'h0080;
      n0 = n_wr;
      core_i.setp(16'h0180);
      core_i.store_cmd({3'h4, CMD_WRITE}, 0);
      t0 = cyc;
      wait_op();
      repeat (3) @(posedge core_clk);
      chk("irq", 16'h1, {15'h0, prog_irq});
      chk("writes", n0 + 1, n_wr);
      chk("halt", 16'h1, {15'h0, halt_seen});
      rdbuf(16'h0184, 8'hff);
      core_i.load(16'h0184, 16'h5a5a);
      core_i.store_cmd({3'h0, CMD_REEN}, 0);
      repeat (2) @(posedge core_clk);
      chk("busy", 16'h0, {15'h0, rww_read_block});
      chk("irq", 16'h0, {15'h0, prog_irq});
      rdbuf(16'h0184, 8'hff);
      $display("t_prog done");
   endtask : t_prog
   task automatic t_guard;
      n0 = n_er;
      core_i.store_cmd({3'h0, CMD_ERASE}, 3);
      rdc(OFS_CTRL, 8'h00, "ctrl");
      core_i.load(16'h0102, 16'h7788);
      eeprom_write_active <= 1'b1;
      repeat (4) @(posedge core_clk);
      core_i.store_cmd({3'h0, CMD_ERASE}, 0);
      rdc(OFS_LOCK, 8'h00, "lock_read");
      chk("erases", n0, n_er);
      eeprom_write_active <= 1'b0;
      repeat (4) @(posedge core_clk);
      rdbuf(16'h0102, 8'hff);
      $display("t_guard done");
   endtask : t_guard
   task automatic t_lock;
      halt_seen = 1'b0;
      block_seen = 1'b0;
      core_i.setp(16'h0001);
      core_i.wr(OFS_DATA_LO, 8'hf5);
      core_i.store_cmd({3'h4, CMD_LOCKSET}, 2);
      t0 = cyc;
      wait_op();
      chk("locks", 16'h0035, {10'h0, lock_bits});
      core_i.setp(16'hffff);
      core_i.wr(OFS_DATA_LO, 8'hfe);
      core_i.store_cmd({3'h4, CMD_LOCKSET}, 0);
      t0 = cyc;
      wait_op();
      chk("locks", 16'h0034, {10'h0, lock_bits});
      chk("halt", 16'h0, {15'h0, halt_seen});
      chk("block", 16'h0, {15'h0, block_seen});
      $display("t_lock done");
   endtask : t_lock
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_vector();
      t_prog();
      t_guard();
      t_lock();
      test_done();
   end
endmodule : flash_self_program_ctrl_test
